//--- tpem_pkg.sv
// Package: event lanes, identifiers and carriers of the translation event map
package tpem_pkg;

  localparam int SID_W    = 24;
  localparam int CU_LANES = 31;
  localparam int BU_LANES = 4;
  localparam int CU_RAW_W = 28;

  // Central unit lanes
  localparam int CU_L_CYC  = 0;
  localparam int CU_L_REQ  = 1;
  localparam int CU_L_RAW0 = 2;
  localparam int CU_L_ATS  = 6;
  localparam int CU_L_WC0  = 7;
  localparam int CU_L_ERR0 = 23;

  // Buffer unit lanes
  localparam int BU_L_CYC = 0;
  localparam int BU_L_TXN = 1;
  localparam int BU_L_TRQ = 2;
  localparam int BU_L_ATS = 3;

  // Event identifiers
  localparam logic [7:0] EV_CYCLE    = 8'h00;
  localparam logic [7:0] EV_WC_BASE  = 8'h80;
  localparam logic [7:0] EV_ERR_BASE = 8'hc0;
  localparam logic [7:0] EV_BU_TXN   = 8'h01;
  localparam logic [7:0] EV_BU_TRQ   = 8'h02;
  localparam logic [7:0] EV_BU_ATS   = 8'h07;

  typedef struct packed {
    logic             valid;
    logic             ats;
    logic             spec;
    logic [SID_W-1:0] sid;
  } tpem_req_t;

  typedef struct packed {
    logic             en;
    logic [SID_W-1:0] sid;
  } tpem_flt_t;

  // Lanes below the walk caches carry their identifier as the lane number
  function automatic logic [7:0] tpem_cu_event_id(input int lane);
    if (lane < CU_L_WC0) begin
      return 8'(lane);
    end else if (lane < CU_L_ERR0) begin
      return EV_WC_BASE + 8'(lane - CU_L_WC0);
    end else begin
      return EV_ERR_BASE + 8'(lane - CU_L_ERR0);
    end
  endfunction

  function automatic logic [7:0] tpem_bu_event_id(input int lane);
    case (lane)
      BU_L_TXN: return EV_BU_TXN;
      BU_L_TRQ: return EV_BU_TRQ;
      BU_L_ATS: return EV_BU_ATS;
      default:  return EV_CYCLE;
    endcase
  endfunction

endpackage

//--- tpem_evt_lane.sv
// One event lane: stream filter, secure gate and registered pulse
`timescale 1ns/10ps
module tpem_evt_lane #(
  parameter bit FILTERABLE = 1'b1,
  parameter bit SECURE     = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Event in
  input  wire logic raw,
  input  wire logic match,
  input  wire logic secure_obs,
  // Increment out
  output logic      inc
);

  logic next_inc;

  always_comb begin
    next_inc = raw;
    if (FILTERABLE && !match) begin
      next_inc = 1'b0;
    end
    if (SECURE && !secure_obs) begin
      next_inc = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inc <= 1'b0;
    end else begin
      inc <= next_inc;
    end
  end

endmodule

//--- tpem_event_map.sv
// Top: event sources of the translation units mapped onto counter lanes
`timescale 1ns/10ps
module tpem_event_map (
  // Clock and reset
  input  wire logic                        CLK_SYS,
  input  wire logic                        RST,
  // Low-power clock state, asynchronous
  input  wire logic                        LPI_GATED,
  // Counter group settings
  input  wire tpem_pkg::tpem_flt_t         CU_FLT,
  input  wire tpem_pkg::tpem_flt_t         BU_FLT,
  input  wire logic                        SECURE_OBS,
  // Central unit sources
  input  wire tpem_pkg::tpem_req_t         CU_REQ,
  input  wire logic [tpem_pkg::SID_W-1:0]  CU_SID,
  input  wire logic [tpem_pkg::CU_RAW_W-1:0] CU_EVT,
  // Buffer unit sources
  input  wire tpem_pkg::tpem_req_t         BU_TXN,
  input  wire tpem_pkg::tpem_req_t         BU_TRQ,
  // Central unit increments
  output logic [tpem_pkg::CU_LANES-1:0]    CU_INC,
  output logic [tpem_pkg::SID_W-1:0]       CU_INC_SID,
  // Buffer unit increments
  output logic [tpem_pkg::BU_LANES-1:0]    BU_INC,
  output logic [tpem_pkg::SID_W-1:0]       BU_TXN_SID,
  output logic [tpem_pkg::SID_W-1:0]       BU_TRQ_SID
);

  logic                          gated_meta;
  logic                          gated_q;
  logic                          cu_req_match;
  logic                          cu_evt_match;
  logic                          bu_txn_match;
  logic                          bu_trq_match;
  logic [tpem_pkg::CU_LANES-1:0] cu_raw;
  logic [tpem_pkg::CU_LANES-1:0] cu_match;
  logic [tpem_pkg::BU_LANES-1:0] bu_raw;
  logic [tpem_pkg::BU_LANES-1:0] bu_match;

  // Gated state comes from the clock controller, so it is synchronised
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      gated_meta <= 1'b0;
      gated_q    <= 1'b0;
    end else begin
      gated_meta <= LPI_GATED;
      gated_q    <= gated_meta;
    end
  end

  // Match ignores spec status so those requests filter too
  assign cu_req_match = !CU_FLT.en || (CU_REQ.sid == CU_FLT.sid);
  assign cu_evt_match = !CU_FLT.en || (CU_SID == CU_FLT.sid);
  assign bu_txn_match = !BU_FLT.en || (BU_TXN.sid == BU_FLT.sid);
  assign bu_trq_match = !BU_FLT.en || (BU_TRQ.sid == BU_FLT.sid);

  genvar gi;
  generate
    for (gi = 0; gi < tpem_pkg::CU_LANES; gi++) begin : g_cu
      if (gi == tpem_pkg::CU_L_CYC) begin : g_cyc
        assign cu_raw[gi]   = !gated_q;
        assign cu_match[gi] = 1'b1;
      end else if (gi == tpem_pkg::CU_L_REQ) begin : g_req
        assign cu_raw[gi]   = CU_REQ.valid;
        assign cu_match[gi] = cu_req_match;
      end else if (gi == tpem_pkg::CU_L_ATS) begin : g_ats
        assign cu_raw[gi]   = CU_REQ.valid && CU_REQ.ats;
        assign cu_match[gi] = cu_req_match;
      end else if (gi < tpem_pkg::CU_L_ATS) begin : g_walk
        // Lanes 0x2 to 0x5 pass table and structure walk events
        assign cu_raw[gi]   = CU_EVT[gi-tpem_pkg::CU_L_RAW0];
        assign cu_match[gi] = cu_evt_match;
      end else begin : g_wc
        // Walk cache lookups, misses and corrected errors
        assign cu_raw[gi]   = CU_EVT[gi-tpem_pkg::CU_L_RAW0-1];
        assign cu_match[gi] = cu_evt_match;
      end
      tpem_evt_lane #(
        .FILTERABLE (gi != tpem_pkg::CU_L_CYC && gi < tpem_pkg::CU_L_ERR0),
        .SECURE     (gi >= tpem_pkg::CU_L_ERR0)
      ) u_lane (
        .clk        (CLK_SYS),
        .rst        (RST),
        .raw        (cu_raw[gi]),
        .match      (cu_match[gi]),
        .secure_obs (SECURE_OBS),
        .inc        (CU_INC[gi])
      );
    end
  endgenerate

  assign bu_raw[tpem_pkg::BU_L_CYC]   = !gated_q;
  assign bu_raw[tpem_pkg::BU_L_TXN]   = BU_TXN.valid;
  assign bu_raw[tpem_pkg::BU_L_TRQ]   = BU_TRQ.valid && !BU_TRQ.spec;
  assign bu_raw[tpem_pkg::BU_L_ATS]   = BU_TXN.valid && BU_TXN.ats;
  assign bu_match[tpem_pkg::BU_L_CYC] = 1'b1;
  assign bu_match[tpem_pkg::BU_L_TXN] = bu_txn_match;
  assign bu_match[tpem_pkg::BU_L_TRQ] = bu_trq_match;
  assign bu_match[tpem_pkg::BU_L_ATS] = bu_txn_match;

  generate
    for (gi = 0; gi < tpem_pkg::BU_LANES; gi++) begin : g_bu
      tpem_evt_lane #(
        .FILTERABLE (gi != tpem_pkg::BU_L_CYC),
        .SECURE     (1'b0)
      ) u_lane (
        .clk        (CLK_SYS),
        .rst        (RST),
        .raw        (bu_raw[gi]),
        .match      (bu_match[gi]),
        .secure_obs (SECURE_OBS),
        .inc        (BU_INC[gi])
      );
    end
  endgenerate

  // Stream identifiers travel alongside the pulses; all central unit lanes share one, the request's when CU_REQ is valid, else CU_SID
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      CU_INC_SID <= '0;
    end else if (CU_REQ.valid) begin
      CU_INC_SID <= CU_REQ.sid;
    end else begin
      CU_INC_SID <= CU_SID;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      BU_TXN_SID <= '0;
      BU_TRQ_SID <= '0;
    end else begin
      BU_TXN_SID <= BU_TXN.sid;
      BU_TRQ_SID <= BU_TRQ.sid;
    end
  end

  property p_cyc_gated;
    @(posedge CLK_SYS) disable iff (RST)
      gated_q |=> !CU_INC[0] && !BU_INC[0];
  endproperty
  a_cyc_gated: assert property (p_cyc_gated)
    else $error("cycle event counted while clock gated");

  // Lanes capture from the first edge after release, so only edges with RST high are skipped
  property p_cyc_run;
    @(posedge CLK_SYS) disable iff (RST)
      !RST && !gated_q |=> CU_INC[0] && BU_INC[0];
  endproperty
  a_cyc_run: assert property (p_cyc_run)
    else $error("cycle event missing while clock runs");

  property p_filter_off;
    @(posedge CLK_SYS) disable iff (RST)
      CU_FLT.en && CU_SID != CU_FLT.sid |=> CU_INC[5:2] == 4'h0;
  endproperty
  a_filter_off: assert property (p_filter_off)
    else $error("walk event counted for another stream");

  property p_spec_filter;
    @(posedge CLK_SYS) disable iff (RST)
      CU_REQ.valid && CU_REQ.spec && CU_FLT.en && CU_REQ.sid != CU_FLT.sid
      |=> !CU_INC[1];
  endproperty
  a_spec_filter: assert property (p_spec_filter)
    else $error("speculative request escaped stream filter");

  property p_req;
    @(posedge CLK_SYS) disable iff (RST)
      CU_REQ.valid && (!CU_FLT.en || CU_REQ.sid == CU_FLT.sid)
      |=> CU_INC[1] && CU_INC_SID == $past(CU_REQ.sid);
  endproperty
  a_req: assert property (p_req)
    else $error("received request not signalled");

  property p_ats_only;
    @(posedge CLK_SYS) disable iff (RST)
      !(CU_REQ.valid && CU_REQ.ats) |=> !CU_INC[6];
  endproperty
  a_ats_only: assert property (p_ats_only)
    else $error("service event without service request");

  property p_bu_txn;
    @(posedge CLK_SYS) disable iff (RST)
      BU_TXN.valid && (!BU_FLT.en || BU_TXN.sid == BU_FLT.sid)
      |=> BU_INC[1] && BU_INC[3] == $past(BU_TXN.ats);
  endproperty
  a_bu_txn: assert property (p_bu_txn)
    else $error("downstream transaction not signalled");

  property p_bu_spec;
    @(posedge CLK_SYS) disable iff (RST)
      BU_TRQ.valid && BU_TRQ.spec |=> !BU_INC[2];
  endproperty
  a_bu_spec: assert property (p_bu_spec)
    else $error("speculative request counted");

  property p_secure;
    @(posedge CLK_SYS) disable iff (RST)
      !SECURE_OBS |=> CU_INC[30:23] == 8'h00;
  endproperty
  a_secure: assert property (p_secure)
    else $error("error event visible without secure observation");

  property p_wc_pulse;
    @(posedge CLK_SYS) disable iff (RST)
      !CU_EVT[4] |=> !CU_INC[7];
  endproperty
  a_wc_pulse: assert property (p_wc_pulse)
    else $error("walk cache lookup pulse without source");

endmodule

//--- tb_tpem_event_map.sv
// Testbench: directed scenarios for the translation event map
`timescale 1ns/10ps
module tb_tpem_event_map;
  localparam int LIMIT = 2000;

  logic                          clk_sys;
  logic                          rst;
  logic                          lpi_gated;
  tpem_pkg::tpem_flt_t           cu_flt;
  tpem_pkg::tpem_flt_t           bu_flt;
  logic                          secure_obs;
  tpem_pkg::tpem_req_t           cu_req;
  logic [tpem_pkg::SID_W-1:0]    cu_sid;
  logic [tpem_pkg::CU_RAW_W-1:0] cu_evt;
  tpem_pkg::tpem_req_t           bu_txn;
  tpem_pkg::tpem_req_t           bu_trq;
  logic [tpem_pkg::CU_LANES-1:0] cu_inc;
  logic [tpem_pkg::SID_W-1:0]    cu_inc_sid;
  logic [tpem_pkg::BU_LANES-1:0] bu_inc;
  logic [tpem_pkg::SID_W-1:0]    bu_txn_sid;
  logic [tpem_pkg::SID_W-1:0]    bu_trq_sid;
  int                            err_total;
  int                            tests_run;
  int                            cycles;

  tpem_event_map i_dut (
    .CLK_SYS    (clk_sys),
    .RST        (rst),
    .LPI_GATED  (lpi_gated),
    .CU_FLT     (cu_flt),
    .BU_FLT     (bu_flt),
    .SECURE_OBS (secure_obs),
    .CU_REQ     (cu_req),
    .CU_SID     (cu_sid),
    .CU_EVT     (cu_evt),
    .BU_TXN     (bu_txn),
    .BU_TRQ     (bu_trq),
    .CU_INC     (cu_inc),
    .CU_INC_SID (cu_inc_sid),
    .BU_INC     (bu_inc),
    .BU_TXN_SID (bu_txn_sid),
    .BU_TRQ_SID (bu_trq_sid)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic conclude();
    $display("Mismatches %0d in %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // A hang in any scenario still reaches the verdict
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_total++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Pulses last one cycle, so outputs are judged one edge after launch
  task automatic land();
    @(posedge clk_sys);
    cu_req <= '0;
    cu_evt <= '0;
    bu_txn <= '0;
    bu_trq <= '0;
    @(negedge clk_sys);
  endtask

  task automatic gate(input logic g);
    @(posedge clk_sys);
    lpi_gated <= g;
    repeat (2) @(posedge clk_sys);
    // Lanes still show the old state, then flip three edges after the pin
    @(negedge clk_sys);
    check(32'({cu_inc[0], bu_inc[0]}), 32'({2{g}}));
    @(negedge clk_sys);
    check(32'({cu_inc[0], bu_inc[0]}), 32'({2{~g}}));
  endtask

  task automatic t_cycle();
    @(posedge clk_sys);
    cu_flt <= {1'b1, 24'h000001};
    bu_flt <= {1'b1, 24'h000001};
    @(negedge clk_sys);
    check(32'({cu_inc[0], bu_inc[0]}), 32'h3);
    gate(1'b1);
    gate(1'b0);
  endtask

  task automatic req(input logic a, input logic s, input logic [23:0] sid,
                     input logic [31:0] exp);
    @(posedge clk_sys);
    cu_req <= {1'b1, a, s, sid};
    land();
    check(32'(cu_inc), exp);
    check(32'(cu_inc_sid), 32'(sid));
    @(negedge clk_sys);
    check(32'(cu_inc), 32'h1);
  endtask

  task automatic t_req();
    @(posedge clk_sys);
    cu_flt <= '0;
    req(1'b0, 1'b0, 24'h000005, 32'h03);
    req(1'b1, 1'b0, 24'h000005, 32'h43);
    @(posedge clk_sys);
    cu_flt <= {1'b1, 24'h000005};
    req(1'b1, 1'b1, 24'h000006, 32'h01);
    req(1'b1, 1'b1, 24'h000005, 32'h43);
  endtask

  task automatic ev(input int b, input logic [31:0] exp);
    @(posedge clk_sys);
    cu_evt <= 28'h1 << b;
    land();
    check(32'(cu_inc), exp);
  endtask

  task automatic t_evt();
    @(posedge clk_sys);
    cu_flt <= '0;
    secure_obs <= 1'b1;
    cu_sid <= 24'h000033;
    // Every raw source once, walk caches and errors included
    for (int b = 0; b < 28; b++) begin
      ev(b, 32'h1 | (32'h1 << ((b < 4) ? b + 2 : b + 3)));
      check(32'(cu_inc_sid), 32'h33);
    end
    @(posedge clk_sys);
    secure_obs <= 1'b0;
    ev(20, 32'h1);
    ev(27, 32'h1);
    @(posedge clk_sys);
    secure_obs <= 1'b1;
    cu_flt <= {1'b1, 24'h000034};
    ev(0, 32'h1);
    ev(5, 32'h1);
    ev(20, 32'h1 | (32'h1 << 23));
    @(posedge clk_sys);
    cu_flt <= {1'b1, 24'h000033};
    ev(4, 32'h1 | (32'h1 << 7));
  endtask

  task automatic bu(input logic [26:0] txn, input logic [26:0] trq,
                    input logic [3:0] exp);
    @(posedge clk_sys);
    bu_txn <= txn;
    bu_trq <= trq;
    land();
    check(32'(bu_inc), 32'(exp));
    check(32'(bu_txn_sid), 32'(txn[23:0]));
    check(32'(bu_trq_sid), 32'(trq[23:0]));
  endtask

  task automatic t_bu();
    @(posedge clk_sys);
    bu_flt <= '0;
    bu({3'b100, 24'h000007}, '0, 4'b0011);
    bu({3'b110, 24'h000008}, '0, 4'b1011);
    bu('0, {3'b100, 24'h000009}, 4'b0101);
    bu('0, {3'b101, 24'h000009}, 4'b0001);
    bu({3'b110, 24'h000009}, {3'b100, 24'h000009}, 4'b1111);
    @(posedge clk_sys);
    bu_flt <= {1'b1, 24'h000009};
    bu({3'b110, 24'h000007}, {3'b100, 24'h000009}, 4'b0101);
    bu({3'b100, 24'h000009}, {3'b100, 24'h000007}, 4'b0011);
  endtask

  initial begin
    err_total = 0;
    tests_run = 0;
    cycles = 0;
    rst = 1'b1;
    lpi_gated = 1'b0;
    cu_flt = '0;
    bu_flt = '0;
    secure_obs = 1'b0;
    cu_req = '0;
    cu_sid = '0;
    cu_evt = '0;
    bu_txn = '0;
    bu_trq = '0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    // Gate synchroniser resets ungated, so cycle lanes pulse from the first edge after reset
    repeat (3) @(posedge clk_sys);
    t_cycle();
    t_req();
    t_evt();
    t_bu();
    conclude();
  end
endmodule
